// [verilog/prd_dma_defs.svh]
/*
 * Constants of the peripheral RAM DMA block: counter width, RAM window,
 * AHB encodings and reset values.
 * Assumes it is included by its bare name from the package and modules.
 */
`ifndef PRD_DMA_DEFS_SVH
`define PRD_DMA_DEFS_SVH

// Channel indices and count
`define PRD_NUM_CH 2
`define PRD_CH_READ 0
`define PRD_CH_WRITE 1

// Byte counter width and its constants
`define PRD_CNT_W 16
`define PRD_CNT_RST 16'h0000
`define PRD_CNT_ONE 16'h0001

// Data RAM window, the only region the channels may address
`define PRD_RAM_BASE 32'h2000_0000
`define PRD_RAM_SIZE 32'h0001_0000

// Address reset value and step
`define PRD_ADDR_RST 32'h0000_0000
`define PRD_ADDR_ONE 32'h0000_0001

// AHB encodings
`define PRD_HTRANS_IDLE 2'h0
`define PRD_HTRANS_NONSEQ 2'h2
`define PRD_HSIZE_BYTE 3'h0
`define PRD_HBURST_SINGLE 3'h0

`endif

// [verilog/prd_pkg.sv]
/*
 * Types of the peripheral RAM DMA block: channel configuration, channel
 * status and state enumerations.
 * Assumes prd_dma_defs.svh is on the include path.
 */
`include "prd_dma_defs.svh"

package prd_pkg;

	// Software settings of one channel
	typedef struct packed {
		logic [31:0] buffer_pointer;
		logic [`PRD_CNT_W-1:0] max_count;
		logic list_en;
	} prd_cfg_t;

	// Status of one channel
	typedef struct packed {
		logic busy;
		logic done;
		logic fault;
		logic [`PRD_CNT_W-1:0] bytes_moved_count;
	} prd_stat_t;

	// Channel sequencer states
	typedef enum logic [1:0] {
		CH_IDLE,
		CH_XFER,
		CH_PUSH
	} prd_ch_state_t;

	// Shared AHB master states
	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_ADDR,
		BUS_DATA
	} prd_bus_state_t;

endpackage : prd_pkg

// [verilog/prd_ram_chk.sv]
/*
 * Address window check: flags whether a byte address lies in data RAM.
 * Assumes a purely combinational use by the channel sequencer.
 */
`timescale 1ns/10ps
`include "prd_dma_defs.svh"

module prd_ram_chk import prd_pkg::*; (
	// Address under test
	input wire logic [31:0] addr,
	// High when the address is inside data RAM
	output logic in_ram
);

	localparam logic [32:0] LOW = {1'b0, `PRD_RAM_BASE};
	localparam logic [32:0] LIMIT = LOW + {1'b0, `PRD_RAM_SIZE};

	// Compare in 33 bits so the window end cannot wrap
	assign in_ram = ({1'b0, addr} >= LOW) && ({1'b0, addr} < LIMIT);

endmodule : prd_ram_chk

// [verilog/prd_dma.sv]
/*
 * Two DMA channels of one peripheral (read and write) sharing one AHB
 * master port towards data RAM, with byte streams to the peripheral core.
 * Assumes an AHB-Lite layer with a request/grant pair from the
 * interconnect, and settings held stable while a channel is busy.
 */
`timescale 1ns/10ps
`include "prd_dma_defs.svh"

module prd_dma import prd_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Channel settings, start pulses and status
	input wire prd_cfg_t [`PRD_NUM_CH-1:0] ch_cfg,
	input wire logic [`PRD_NUM_CH-1:0] ch_start,
	output prd_stat_t [`PRD_NUM_CH-1:0] ch_stat,
	output logic bus_fault_exception,
	// Read stream to the peripheral core
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire logic rd_ready,
	// Write stream from the peripheral core
	input wire logic [7:0] wr_data,
	input wire logic wr_last,
	input wire logic wr_valid,
	output logic wr_ready,
	// AHB master port
	output logic hbusreq,
	input wire logic hgrant,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [2:0] hburst,
	output logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hready,
	input wire logic hresp
);

	logic [`PRD_NUM_CH-1:0] ch_req;
	logic [`PRD_NUM_CH-1:0] ch_wr;
	logic [31:0] ch_addr [`PRD_NUM_CH];
	logic [7:0] ch_byte [`PRD_NUM_CH];
	logic [`PRD_NUM_CH-1:0] bus_done;
	logic [`PRD_NUM_CH-1:0] fault_vec;
	logic [7:0] bus_rbyte;
	prd_bus_state_t bus_q, bus_d;
	logic owner_q, owner_d;
	logic [31:0] haddr_q, haddr_d;
	logic hwrite_q, hwrite_d;
	logic [7:0] hwbyte_q, hwbyte_d;

	// Shared master: next address phase, ownership and data phase
	always_comb begin
		bus_d = bus_q;
		owner_d = owner_q;
		haddr_d = haddr_q;
		hwrite_d = hwrite_q;
		hwbyte_d = hwbyte_q;
		case (bus_q)
			BUS_IDLE: begin
				// Wait for the interconnect grant before driving
				if ((|ch_req) && hgrant) begin
					// Read channel wins a tie
					owner_d = ch_req[`PRD_CH_READ] ? 1'b0 : 1'b1;
					haddr_d = ch_addr[owner_d];
					hwrite_d = ch_wr[owner_d];
					hwbyte_d = wr_data;
					bus_d = BUS_ADDR;
				end
			end
			BUS_ADDR: begin
				if (hready) begin
					bus_d = BUS_DATA;
				end
			end
			BUS_DATA: begin
				if (hready) begin
					bus_d = BUS_IDLE;
				end
			end
			default: begin
				bus_d = BUS_IDLE;
			end
		endcase
	end

	// Shared master registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bus_q <= BUS_IDLE;
			owner_q <= 1'b0;
			haddr_q <= `PRD_ADDR_RST;
			hwrite_q <= 1'b0;
			hwbyte_q <= 8'h00;
		end else begin
			bus_q <= bus_d;
			owner_q <= owner_d;
			haddr_q <= haddr_d;
			hwrite_q <= hwrite_d;
			hwbyte_q <= hwbyte_d;
		end
	end

	// AHB outputs: single byte transfers, byte on every lane
	assign hbusreq = (|ch_req) || (bus_q != BUS_IDLE);
	assign htrans = (bus_q == BUS_ADDR) ? `PRD_HTRANS_NONSEQ
		: `PRD_HTRANS_IDLE;
	assign haddr = haddr_q;
	assign hwrite = hwrite_q;
	assign hsize = `PRD_HSIZE_BYTE;
	assign hburst = `PRD_HBURST_SINGLE;
	assign hwdata = {4{hwbyte_q}};
	assign bus_rbyte = hrdata[{haddr_q[1:0], 3'b000} +: 8];
	assign bus_done[0] = (bus_q == BUS_DATA) && hready && !owner_q;
	assign bus_done[1] = (bus_q == BUS_DATA) && hready && owner_q;

	// Streams and the fault output
	assign rd_data = ch_byte[`PRD_CH_READ];
	assign bus_fault_exception = |fault_vec;

	// One sequencer per channel
	for (genvar c = 0; c < `PRD_NUM_CH; c++) begin : g_ch
		localparam bit IS_WR = (c == `PRD_CH_WRITE);
		localparam bit HAS_LIST = (c == `PRD_CH_READ);
		prd_ch_state_t st_q, st_d;
		logic [31:0] addr_q, addr_d;
		logic [31:0] base_q, base_d;
		logic [31:0] next_q, next_d;
		logic list_ok_q, list_ok_d;
		logic [`PRD_CNT_W-1:0] cnt_q, cnt_d;
		logic [`PRD_CNT_W-1:0] moved_q, moved_d;
		logic [7:0] byte_q, byte_d;
		logic done_q, done_d;
		logic fault_q, fault_d;
		logic in_ram;
		logic fin;

		prd_ram_chk u_chk (
			.addr(addr_q),
			.in_ram(in_ram)
		);

		// Next state of the channel
		always_comb begin
			st_d = st_q;
			addr_d = addr_q;
			base_d = base_q;
			next_d = next_q;
			list_ok_d = list_ok_q;
			cnt_d = cnt_q;
			moved_d = moved_q;
			byte_d = byte_q;
			done_d = 1'b0;
			fault_d = 1'b0;
			fin = 1'b0;
			case (st_q)
				CH_IDLE: begin
					if (!(HAS_LIST && ch_cfg[c].list_en)) begin
						list_ok_d = 1'b0;
					end
					if (ch_start[c]) begin
						// Item follows the last one in list mode
						if (HAS_LIST && ch_cfg[c].list_en && list_ok_q) begin
							addr_d = next_q;
						end else begin
							addr_d = ch_cfg[c].buffer_pointer;
						end
						base_d = addr_d;
						cnt_d = `PRD_CNT_RST;
						if (ch_cfg[c].max_count == `PRD_CNT_RST) begin
							fin = 1'b1;
						end else begin
							st_d = CH_XFER;
						end
					end
				end
				CH_XFER: begin
					if (!in_ram && !(bus_q != BUS_IDLE && owner_q == c)) begin
						// Refuse the access and end with a fault
						fault_d = 1'b1;
						fin = 1'b1;
					end else if (bus_done[c]) begin
						if (hresp) begin
							fault_d = 1'b1;
							fin = 1'b1;
						end else if (IS_WR) begin
							cnt_d = cnt_q + `PRD_CNT_ONE;
							addr_d = addr_q + `PRD_ADDR_ONE;
							// Stop at max_count or at the core's last byte
							fin = (cnt_d == ch_cfg[c].max_count) || wr_last;
						end else begin
							byte_d = bus_rbyte;
							st_d = CH_PUSH;
						end
					end
				end
				CH_PUSH: begin
					if (rd_ready) begin
						cnt_d = cnt_q + `PRD_CNT_ONE;
						addr_d = addr_q + `PRD_ADDR_ONE;
						// Item is full after max_count bytes
						if (cnt_d == ch_cfg[c].max_count) begin
							fin = 1'b1;
						end else begin
							st_d = CH_XFER;
						end
					end
				end
				default: begin
					st_d = CH_IDLE;
				end
			endcase
			if (fin) begin
				st_d = CH_IDLE;
				done_d = 1'b1;
				moved_d = cnt_d;
				if (HAS_LIST && ch_cfg[c].list_en) begin
					// Next item starts max_count bytes on
					next_d = base_d + {16'h0000, ch_cfg[c].max_count};
					list_ok_d = 1'b1;
				end
			end
		end

		// Channel registers
		always_ff @(posedge clk_sys or negedge arst_n) begin
			if (!arst_n) begin
				st_q <= CH_IDLE;
				addr_q <= `PRD_ADDR_RST;
				base_q <= `PRD_ADDR_RST;
				next_q <= `PRD_ADDR_RST;
				list_ok_q <= 1'b0;
				cnt_q <= `PRD_CNT_RST;
				moved_q <= `PRD_CNT_RST;
				byte_q <= 8'h00;
				done_q <= 1'b0;
				fault_q <= 1'b0;
			end else begin
				st_q <= st_d;
				addr_q <= addr_d;
				base_q <= base_d;
				next_q <= next_d;
				list_ok_q <= list_ok_d;
				cnt_q <= cnt_d;
				moved_q <= moved_d;
				byte_q <= byte_d;
				done_q <= done_d;
				fault_q <= fault_d;
			end
		end

		// Bus request: write waits for a byte, both only inside RAM
		assign ch_req[c] = (st_q == CH_XFER) && in_ram && !bus_done[c]
			&& !(bus_q != BUS_IDLE && owner_q == c)
			&& (!IS_WR || wr_valid);
		assign ch_wr[c] = IS_WR;
		assign ch_addr[c] = addr_q;
		assign ch_byte[c] = byte_q;
		assign fault_vec[c] = fault_q;

		// Status of the channel
		always_comb begin
			ch_stat[c].busy = (st_q != CH_IDLE);
			ch_stat[c].done = done_q;
			ch_stat[c].fault = fault_q;
			ch_stat[c].bytes_moved_count = moved_q;
		end

		// A read item that finished without a fault moved exactly max_count bytes
		a_rd_count_exact: assert property (@(posedge clk_sys)
			disable iff (!arst_n)
			(!IS_WR && done_q && !fault_q) |-> moved_q == ch_cfg[c].max_count)
			else $error("read channel moved a wrong byte count");

		// A write never moves more than max_count bytes
		a_wr_not_over: assert property (@(posedge clk_sys)
			disable iff (!arst_n)
			done_q |-> moved_q <= ch_cfg[c].max_count)
			else $error("channel moved more than max_count");

		// Count reported on completion is the count reached
		a_moved_update: assert property (@(posedge clk_sys)
			disable iff (!arst_n)
			$rose(done_q) && !fault_q |-> moved_q == cnt_q)
			else $error("bytes moved not updated at transfer end");

		// Out-of-RAM address raises a fault next cycle, no request
		a_fault_no_bus: assert property (@(posedge clk_sys)
			disable iff (!arst_n)
			(st_q == CH_XFER && !in_ram && bus_q == BUS_IDLE)
			|-> !ch_req[c] ##1 (fault_q && st_q == CH_IDLE))
			else $error("invalid pointer did not fault");

		// Only the read channel keeps an item chain
		a_list_only_rd: assert property (@(posedge clk_sys)
			disable iff (!arst_n)
			!HAS_LIST |-> !list_ok_q)
			else $error("item sequence on a channel without it");

		// A chained start resumes right after the previous item
		a_list_advance: assert property (@(posedge clk_sys)
			disable iff (!arst_n)
			(st_q == CH_IDLE && ch_start[c] && list_ok_q && ch_cfg[c].list_en
			&& HAS_LIST) |=> addr_q == $past(next_q))
			else $error("item sequence did not advance");

		// A plain start loads buffer_pointer
		a_start_addr: assert property (@(posedge clk_sys)
			disable iff (!arst_n)
			(st_q == CH_IDLE && ch_start[c]
			&& !(list_ok_q && ch_cfg[c].list_en))
			|=> addr_q == $past(ch_cfg[c].buffer_pointer))
			else $error("start did not load buffer_pointer");
	end

	// Accept a write byte only when its bus write completes
	assign wr_ready = bus_done[`PRD_CH_WRITE]
		&& (g_ch[`PRD_CH_WRITE].st_q == CH_XFER) && !hresp;
	assign rd_valid = (g_ch[`PRD_CH_READ].st_q == CH_PUSH);

	// Address phase steps to data phase once the slave is ready
	sequence s_addr_done;
		(bus_q == BUS_ADDR) && hready;
	endsequence

	a_addr_phase: assert property (@(posedge clk_sys)
		disable iff (!arst_n)
		s_addr_done |=> (bus_q == BUS_DATA) && htrans == `PRD_HTRANS_IDLE)
		else $error("address phase did not reach data phase");

	// Every issued address lies in data RAM
	a_ram_only: assert property (@(posedge clk_sys)
		disable iff (!arst_n)
		htrans == `PRD_HTRANS_NONSEQ |-> (haddr >= `PRD_RAM_BASE)
		&& ({1'b0, haddr} < {1'b0, `PRD_RAM_BASE} + {1'b0, `PRD_RAM_SIZE}))
		else $error("access outside data RAM");

	// No transfer starts without the grant
	a_stall_no_grant: assert property (@(posedge clk_sys)
		disable iff (!arst_n)
		(bus_q == BUS_IDLE && !hgrant) |=> bus_q == BUS_IDLE)
		else $error("transfer started without grant");

	// Read channel wins a simultaneous request
	a_read_prio: assert property (@(posedge clk_sys)
		disable iff (!arst_n)
		(bus_q == BUS_IDLE && hgrant && (&ch_req)) |=> !owner_q)
		else $error("lower priority channel served first");

endmodule : prd_dma

// [bench/prd_ram_model.sv]
/*
 * Behavioural AHB RAM slave: grant, wait states, error reply, byte store.
 * Assumes one byte transfer at a time, RAM decoded on haddr[7:0].
 */
`timescale 1ns/10ps

module prd_ram_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Bench controls
	input wire logic stall_grant,
	input wire logic err_on,
	input wire logic [1:0] wait_n,
	// AHB slave side
	input wire logic hbusreq,
	output logic hgrant,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hready,
	output logic hresp
);
	logic [7:0] mem [0:255];
	logic ph_q;
	logic wr_q;
	logic [7:0] a_q;
	logic [1:0] cnt_q;

	// Grant held back while a higher master owns the slave
	assign hgrant = hbusreq && !stall_grant;
	assign hready = !ph_q || cnt_q == wait_n;
	assign hresp = ph_q && err_on;
	// Outside a read phase the lanes show the inverted byte
	assign hrdata = {4{(ph_q && !wr_q) ? mem[a_q] : ~mem[a_q]}};

	// Known fill pattern
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5A;
		end
	end

	// Address phase capture, wait states and byte store
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ph_q <= 1'b0;
			cnt_q <= 2'h0;
		end else if (!hready) begin
			cnt_q <= cnt_q + 2'h1;
		end else begin
			if (ph_q && wr_q && !err_on) begin
				mem[a_q] <= hwdata[{a_q[1:0], 3'h0} +: 8];
			end
			ph_q <= htrans == 2'h2;
			wr_q <= hwrite;
			a_q <= haddr[7:0];
			cnt_q <= 2'h0;
		end
	end
endmodule : prd_ram_model

// [bench/tb_top.sv]
/*
 * Bench of the two-channel RAM DMA: reads, writes, item sequence,
 * faults and stalls against a behavioural RAM slave.
 * Assumes RAM fill pattern of address low byte xor 0x5A.
 */
`timescale 1ns/10ps
`include "prd_dma_defs.svh"

module tb_top import prd_pkg::*; ();
	localparam logic [31:0] BASE = `PRD_RAM_BASE;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	prd_cfg_t [`PRD_NUM_CH-1:0] ch_cfg = '0;
	logic [`PRD_NUM_CH-1:0] ch_start = '0;
	prd_stat_t [`PRD_NUM_CH-1:0] ch_stat;
	logic bus_fault_exception, rd_valid, wr_ready, hbusreq, hgrant;
	logic [7:0] rd_data;
	logic rd_ready = 1'b1;
	logic [7:0] wr_data = 8'h00;
	logic wr_last = 1'b0;
	logic wr_valid = 1'b0;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, hburst;
	logic hwrite, hready, hresp;
	logic stall_grant = 1'b0;
	logic err_on = 1'b0;
	logic [1:0] wait_n = 2'h0;
	int errors = 0;
	int tests_run = 0;
	int nseq = 0;

	prd_dma u_prd_dma (.clk_sys(clk_sys), .arst_n(arst_n),
		.ch_cfg(ch_cfg), .ch_start(ch_start), .ch_stat(ch_stat),
		.bus_fault_exception(bus_fault_exception), .rd_data(rd_data),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .wr_data(wr_data),
		.wr_last(wr_last), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.hbusreq(hbusreq), .hgrant(hgrant), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hburst(hburst),
		.hwdata(hwdata), .hrdata(hrdata), .hready(hready), .hresp(hresp));

	prd_ram_model u_prd_ram_model (.clk_sys(clk_sys), .arst_n(arst_n),
		.stall_grant(stall_grant), .err_on(err_on), .wait_n(wait_n),
		.hbusreq(hbusreq), .hgrant(hgrant), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
		.hrdata(hrdata), .hready(hready), .hresp(hresp));

	// System clock
	always #5 clk_sys = ~clk_sys;

	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask : check

	// Every address phase stays inside the RAM window
	always @(posedge clk_sys) begin
		if (htrans === 2'h2 && hready === 1'b1) begin
			nseq++;
			check("bus window", 32'h2000, 32'(haddr[31:16]));
			check("bus size", 32'(`PRD_HSIZE_BYTE), 32'(hsize));
			check("bus burst", 32'(`PRD_HBURST_SINGLE), 32'(hburst));
		end
	end

	task automatic rd_xfer(input logic [31:0] p, eb, input logic [15:0] n,
		input logic le, input logic [15:0] em, input logic ef);
		int k;
		logic dn;
		logic fl;
		k = 0;
		dn = 1'b0;
		fl = 1'b0;
		@(negedge clk_sys);
		ch_cfg[0] = '{p, n, le};
		ch_start[0] = 1'b1;
		for (int t = 0; t < 300 && !dn; t++) begin
			@(negedge clk_sys);
			ch_start[0] = 1'b0;
			// Core pauses every third cycle so a byte must wait
			rd_ready = (t % 3) != 1;
			if (t == 0) begin
				check("start busy", 32'(n != 16'h0), 32'(ch_stat[0].busy));
			end
			if (rd_valid === 1'b1 && rd_ready) begin
				check("read byte", 32'((eb[7:0] + 8'(k)) ^ 8'h5A),
					32'(rd_data));
				k++;
			end
			dn = ch_stat[0].done;
			fl = ch_stat[0].fault && bus_fault_exception;
		end
		rd_ready = 1'b1;
		check("read done", 32'h1, 32'(dn));
		check("read count", 32'(em), 32'(ch_stat[0].bytes_moved_count));
		check("read fault", 32'(ef), 32'(fl));
		check("read busy", 32'h0, 32'(ch_stat[0].busy));
	endtask : rd_xfer

	task automatic wr_xfer(input logic [31:0] p, input logic [15:0] n,
		input int nb, input logic [15:0] em);
		int k;
		logic dn;
		logic pend;
		k = 0;
		dn = 1'b0;
		pend = 1'b0;
		@(negedge clk_sys);
		ch_cfg[1] = '{p, n, 1'b1};
		ch_start[1] = 1'b1;
		wr_data = 8'hC0;
		wr_last = nb == 1;
		wr_valid = 1'b1;
		for (int t = 0; t < 300 && !dn; t++) begin
			@(negedge clk_sys);
			ch_start[1] = 1'b0;
			if (pend) begin
				k++;
				wr_data = 8'hC0 + 8'(k);
				wr_last = k == nb - 1;
				wr_valid = k < nb;
			end
			pend = wr_ready;
			dn = ch_stat[1].done;
		end
		wr_valid = 1'b0;
		wr_last = 1'b0;
		check("write done", 32'h1, 32'(dn));
		check("write count", 32'(em), 32'(ch_stat[1].bytes_moved_count));
		for (int i = 0; i <= int'(em); i++) begin
			check("ram byte", i < em ? 32'(8'hC0 + 8'(i)) :
				32'((p[7:0] + 8'(i)) ^ 8'h5A),
				32'(u_prd_ram_model.mem[8'(p[7:0] + 8'(i))]));
		end
	endtask : wr_xfer

	task automatic wrap_up;
		$display("counts: %0d checks, %0d mismatches", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up

	// Test sequence
	initial begin
		int n0;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		arst_n = 1'b1;
		rd_xfer(BASE, BASE, 16'h5, 1'b0, 16'h5, 1'b0);
		wr_xfer(BASE + 32'h10, 16'h6, 8, 16'h6);
		wr_xfer(BASE + 32'h20, 16'h6, 3, 16'h3);
		rd_xfer(BASE, BASE, 16'h0, 1'b0, 16'h0, 1'b0);
		$display("end of test plain transfers");
		for (int i = 0; i < 3; i++) begin
			rd_xfer(BASE + 32'h40, BASE + 32'h40 + 32'(4 * i), 16'h4, 1'b1,
				16'h4, 1'b0);
		end
		rd_xfer(BASE + 32'h40, BASE + 32'h40, 16'h4, 1'b0, 16'h4, 1'b0);
		$display("end of test item sequence");
		n0 = nseq;
		rd_xfer(32'h0000_1000, 32'h0, 16'h4, 1'b0, 16'h0, 1'b1);
		check("no bus access", 32'(n0), 32'(nseq));
		rd_xfer(BASE + 32'hFFFE, 32'hFE, 16'h4, 1'b0, 16'h2, 1'b1);
		err_on = 1'b1;
		rd_xfer(BASE, BASE, 16'h3, 1'b0, 16'h0, 1'b1);
		err_on = 1'b0;
		$display("end of test faults");
		wait_n = 2'h2;
		stall_grant = 1'b1;
		fork
			begin
				repeat (12) @(negedge clk_sys);
				check("stall request", 32'h1, 32'(hbusreq));
				check("stall trans", 32'h0, 32'(htrans));
				stall_grant = 1'b0;
			end
			rd_xfer(BASE + 32'h80, BASE + 32'h80, 16'h4, 1'b0, 16'h4, 1'b0);
			wr_xfer(BASE + 32'hA0, 16'h4, 4, 16'h4);
		join
		$display("end of test stall and both channels");
		wrap_up();
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		$display("watchdog expired");
		wrap_up();
	end
endmodule : tb_top
